// file: hw/level_sync.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module level_sync (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Level
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // level_sync

// file: hw/servo_bank_pkg.sv
// Address map, field positions and value ranges of the servo parameter bank
package servo_bank_pkg;
    // Fieldbus parameter addresses
    localparam logic [15:0] ADDR_D_AXIS_INTEGRAL_TIME = 16'h1104;
    localparam logic [15:0] ADDR_Q_AXIS_PROPORTIONAL_GAIN = 16'h1106;
    localparam logic [15:0] ADDR_Q_AXIS_INTEGRAL_TIME = 16'h1108;
    localparam logic [15:0] ADDR_OPERATING_STATE_WORD = 16'h1b04;
    localparam logic [15:0] ADDR_REFERENCE_SHIFT_COUNT = 16'h1b0a;
    localparam logic [15:0] ADDR_PROFILE_DRIVE_STATE = 16'h1b4a;
    localparam logic [15:0] ADDR_PROFILE_FUNCTION_STATE = 16'h1b4c;
    localparam logic [15:0] ADDR_PROFILE_MOVEMENT_STATE = 16'h1b4e;
    localparam logic [15:0] ADDR_PROFILE_INPUT_STATE = 16'h1b50;
    localparam logic [15:0] ADDR_UNIT_TEMPERATURE = 16'h1c24;

    // Gain in 0.1 V/A counts, integral times in 0.01 ms counts
    localparam logic [15:0] KP_MIN = 16'h0005;
    localparam logic [15:0] KP_MAX = 16'h319c;
    localparam logic [15:0] TN_MIN = 16'h000d;
    localparam logic [15:0] TN_MAX = 16'h7fff;
    localparam logic [15:0] KP_RESET = KP_MIN;
    localparam logic [15:0] TN_RESET = TN_MIN;

    // Reference shift count
    localparam int REF_WIDTH = 16;
    localparam int SHIFT_MAX_INT = 12;
    localparam int VEL_WIDTH = REF_WIDTH + SHIFT_MAX_INT;
    localparam logic [3:0] SHIFT_MAX = 4'hc;
    localparam logic [3:0] SHIFT_RESET = 4'h0;

    // Operating state word bit positions
    localparam int ST_READY = 0;
    localparam int ST_SWITCHED_ON = 1;
    localparam int ST_OP_ENABLED = 2;
    localparam int ST_VOLTAGE = 4;
    localparam int ST_QUICK_STOP = 5;
    localparam int ST_SWITCH_ON_DIS = 6;
    localparam int ST_ERR_CLASS0 = 7;
    localparam int ST_HALT = 8;
    localparam int ST_REMOTE = 9;
    localparam int ST_TARGET = 10;
    localparam int ST_INT_LIMIT = 11;
    localparam int ST_MODE_SPEC = 12;
    localparam int ST_OP_ERROR = 13;
    localparam int ST_OP_END = 14;
    localparam int ST_REF_VALID = 15;
endpackage

// file: hw/servo_status_parameter_bank.sv
// Read-only parameter bank: current loop gains, state word, shift count, profile words
`timescale 1ns/1ps

module servo_status_parameter_bank (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Fieldbus parameter access
    input wire logic rd_req_i,
    input wire logic [15:0] rd_addr_i,
    input wire logic wr_req_i,
    input wire logic [15:0] wr_addr_i,
    output logic [15:0] rd_data_o,
    output logic rd_ack_o,
    output logic rd_unmapped_o,
    output logic wr_refused_o,
    // Motor-data calculation results
    input wire logic gain_load_i,
    input wire logic [15:0] kp_q_calc_i,
    input wire logic [15:0] tn_d_calc_i,
    input wire logic [15:0] tn_q_calc_i,
    // Gains applied by the current controller
    output logic [15:0] kp_q_active_o,
    output logic [15:0] tn_d_active_o,
    output logic [15:0] tn_q_active_o,
    // Power stage enable pin and velocity scaling
    input wire logic power_stage_en_i,
    input wire logic [servo_bank_pkg::VEL_WIDTH-1:0] velocity_scaled_i,
    output logic [3:0] reference_shift_o,
    // Operating state flags
    input wire logic ready_i,
    input wire logic switched_on_i,
    input wire logic op_enabled_i,
    input wire logic voltage_en_i,
    input wire logic quick_stop_i,
    input wire logic switch_on_dis_i,
    input wire logic err_class0_i,
    input wire logic halt_active_i,
    input wire logic remote_i,
    input wire logic target_reached_i,
    input wire logic int_limit_i,
    input wire logic mode_specific_i,
    input wire logic op_error_i,
    input wire logic op_end_i,
    input wire logic ref_valid_i,
    // Profile words and temperature
    input wire logic [15:0] profile_drive_state_i,
    input wire logic [15:0] profile_function_state_i,
    input wire logic [15:0] profile_movement_state_i,
    input wire logic [15:0] profile_input_state_i,
    input wire logic [15:0] unit_temperature_i
);
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic power_en_s;
    logic power_prev_q;
    logic power_prev_d;
    logic power_rise;
    logic [3:0] shift_calc;
    logic [3:0] shift_q;
    logic [3:0] shift_d;
    logic [15:0] kp_q;
    logic [15:0] kp_d;
    logic [15:0] tnd_q;
    logic [15:0] tnd_d;
    logic [15:0] tnq_q;
    logic [15:0] tnq_d;
    logic [15:0] state_word;
    logic [15:0] rd_data_q;
    logic [15:0] rd_data_d;
    logic rd_ack_q;
    logic rd_ack_d;
    logic rd_unmapped_q;
    logic rd_unmapped_d;
    logic wr_refused_q;
    logic wr_refused_d;

    // Enable arrives from the power stage, outside this clock's timing
    level_sync u_power_sync (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(power_stage_en_i),
        .sync_o(power_en_s)
    );

    shift_count_calc u_shift_calc (
        .velocity_i(velocity_scaled_i),
        .shift_o(shift_calc)
    );

    assign power_rise = power_en_s && !power_prev_q;

    // Gain and shift state
    always_comb
    begin
        power_prev_d = power_en_s;
        kp_d = kp_q;
        tnd_d = tnd_q;
        tnq_d = tnq_q;
        shift_d = shift_q;
        if (gain_load_i)
        begin
            kp_d = clamp16(kp_q_calc_i, servo_bank_pkg::KP_MIN, servo_bank_pkg::KP_MAX);
            tnd_d = clamp16(tn_d_calc_i, servo_bank_pkg::TN_MIN, servo_bank_pkg::TN_MAX);
            tnq_d = clamp16(tn_q_calc_i, servo_bank_pkg::TN_MIN, servo_bank_pkg::TN_MAX);
        end
        if (power_rise)
        begin
            shift_d = shift_calc;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            power_prev_q <= 1'b0;
            kp_q <= servo_bank_pkg::KP_RESET;
            tnd_q <= servo_bank_pkg::TN_RESET;
            tnq_q <= servo_bank_pkg::TN_RESET;
            shift_q <= servo_bank_pkg::SHIFT_RESET;
        end
        else
        begin
            power_prev_q <= power_prev_d;
            kp_q <= kp_d;
            tnd_q <= tnd_d;
            tnq_q <= tnq_d;
            shift_q <= shift_d;
        end
    end

    // State word, read live so a read sees the flags of its own cycle
    always_comb
    begin
        state_word = 16'h0000;
        state_word[servo_bank_pkg::ST_READY] = ready_i;
        state_word[servo_bank_pkg::ST_SWITCHED_ON] = switched_on_i;
        state_word[servo_bank_pkg::ST_OP_ENABLED] = op_enabled_i;
        state_word[servo_bank_pkg::ST_VOLTAGE] = voltage_en_i;
        state_word[servo_bank_pkg::ST_QUICK_STOP] = quick_stop_i;
        state_word[servo_bank_pkg::ST_SWITCH_ON_DIS] = switch_on_dis_i;
        state_word[servo_bank_pkg::ST_ERR_CLASS0] = err_class0_i;
        state_word[servo_bank_pkg::ST_HALT] = halt_active_i;
        state_word[servo_bank_pkg::ST_REMOTE] = remote_i;
        state_word[servo_bank_pkg::ST_TARGET] = target_reached_i;
        state_word[servo_bank_pkg::ST_INT_LIMIT] = int_limit_i;
        state_word[servo_bank_pkg::ST_MODE_SPEC] = mode_specific_i;
        state_word[servo_bank_pkg::ST_OP_ERROR] = op_error_i;
        state_word[servo_bank_pkg::ST_OP_END] = op_end_i;
        state_word[servo_bank_pkg::ST_REF_VALID] = ref_valid_i;
    end

    // Read and write answers
    always_comb
    begin
        rd_data_d = 16'h0000;
        rd_ack_d = 1'b0;
        rd_unmapped_d = 1'b0;
        wr_refused_d = wr_req_i;
        if (rd_req_i)
        begin
            rd_ack_d = 1'b1;
            if (rd_addr_i == servo_bank_pkg::ADDR_D_AXIS_INTEGRAL_TIME)
                rd_data_d = tnd_q;
            else if (rd_addr_i == servo_bank_pkg::ADDR_Q_AXIS_PROPORTIONAL_GAIN)
                rd_data_d = kp_q;
            else if (rd_addr_i == servo_bank_pkg::ADDR_Q_AXIS_INTEGRAL_TIME)
                rd_data_d = tnq_q;
            else if (rd_addr_i == servo_bank_pkg::ADDR_OPERATING_STATE_WORD)
                rd_data_d = state_word;
            else if (rd_addr_i == servo_bank_pkg::ADDR_REFERENCE_SHIFT_COUNT)
                rd_data_d = {12'h000, shift_q};
            else if (rd_addr_i == servo_bank_pkg::ADDR_PROFILE_DRIVE_STATE)
                rd_data_d = profile_drive_state_i;
            else if (rd_addr_i == servo_bank_pkg::ADDR_PROFILE_FUNCTION_STATE)
                rd_data_d = profile_function_state_i;
            else if (rd_addr_i == servo_bank_pkg::ADDR_PROFILE_MOVEMENT_STATE)
                rd_data_d = profile_movement_state_i;
            else if (rd_addr_i == servo_bank_pkg::ADDR_PROFILE_INPUT_STATE)
                rd_data_d = profile_input_state_i;
            else if (rd_addr_i == servo_bank_pkg::ADDR_UNIT_TEMPERATURE)
                rd_data_d = unit_temperature_i;
            else
                rd_unmapped_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_data_q <= 16'h0000;
            rd_ack_q <= 1'b0;
            rd_unmapped_q <= 1'b0;
            wr_refused_q <= 1'b0;
        end
        else
        begin
            rd_data_q <= rd_data_d;
            rd_ack_q <= rd_ack_d;
            rd_unmapped_q <= rd_unmapped_d;
            wr_refused_q <= wr_refused_d;
        end
    end

    assign rd_data_o = rd_data_q;
    assign rd_ack_o = rd_ack_q;
    assign rd_unmapped_o = rd_unmapped_q;
    assign wr_refused_o = wr_refused_q;
    assign kp_q_active_o = kp_q;
    assign tn_d_active_o = tnd_q;
    assign tn_q_active_o = tnq_q;
    // The master relies on this count to scale its reference
    assign reference_shift_o = shift_q;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    kp_range_a: assert property (kp_q >= servo_bank_pkg::KP_MIN
        && kp_q <= servo_bank_pkg::KP_MAX)
        else $error("q-axis gain out of range");
    tnd_range_a: assert property (tnd_q >= servo_bank_pkg::TN_MIN
        && tnd_q <= servo_bank_pkg::TN_MAX)
        else $error("d-axis integral time out of range");
    tnq_range_a: assert property (tnq_q >= servo_bank_pkg::TN_MIN
        && tnq_q <= servo_bank_pkg::TN_MAX)
        else $error("q-axis integral time out of range");
    tnd_load_a: assert property (gain_load_i |=> tnd_q == clamp16($past(tn_d_calc_i),
        servo_bank_pkg::TN_MIN, servo_bank_pkg::TN_MAX))
        else $error("d-axis integral time not loaded");
    tnq_load_a: assert property (gain_load_i |=> tnq_q == clamp16($past(tn_q_calc_i),
        servo_bank_pkg::TN_MIN, servo_bank_pkg::TN_MAX))
        else $error("q-axis integral time not loaded");
    gain_immediate_a: assert property (gain_load_i
        |=> kp_q_active_o == clamp16($past(kp_q_calc_i),
        servo_bank_pkg::KP_MIN, servo_bank_pkg::KP_MAX))
        else $error("gain not active after load");
    // Only a load may move a gain; reads and write attempts leave them alone
    load_hold_a: assert property (!gain_load_i
        |=> $stable(kp_q) && $stable(tnd_q) && $stable(tnq_q))
        else $error("gain moved without a load");
    state_low_a: assert property (rd_req_i
        && rd_addr_i == servo_bank_pkg::ADDR_OPERATING_STATE_WORD
        |=> rd_data_o[2:0] == {$past(op_enabled_i), $past(switched_on_i), $past(ready_i)})
        else $error("state word low bits wrong");
    state_gap_a: assert property (rd_req_i
        && rd_addr_i == servo_bank_pkg::ADDR_OPERATING_STATE_WORD
        |=> rd_data_o[3] == 1'b0 && rd_data_o[4] == $past(voltage_en_i))
        else $error("state word bit 3 or 4 wrong");
    state_high_a: assert property (rd_req_i
        && rd_addr_i == servo_bank_pkg::ADDR_OPERATING_STATE_WORD
        |=> rd_data_o[15] == $past(ref_valid_i) && rd_data_o[7] == $past(err_class0_i))
        else $error("state word high bits wrong");
    shift_range_a: assert property (reference_shift_o <= servo_bank_pkg::SHIFT_MAX)
        else $error("shift count above limit");
    shift_read_a: assert property (rd_req_i
        && rd_addr_i == servo_bank_pkg::ADDR_REFERENCE_SHIFT_COUNT
        |=> rd_data_o == {12'h000, $past(shift_q)})
        else $error("shift count read wrong");
    shift_hold_a: assert property (!power_rise |=> $stable(shift_q))
        else $error("shift changed without enable");
    shift_update_a: assert property (power_rise |=> shift_q == $past(shift_calc))
        else $error("shift not recomputed on enable");
    profile_read_a: assert property (rd_req_i
        && rd_addr_i == servo_bank_pkg::ADDR_PROFILE_MOVEMENT_STATE
        |=> rd_ack_o && rd_data_o == $past(profile_movement_state_i))
        else $error("movement word read wrong");
    temp_read_a: assert property (rd_req_i
        && rd_addr_i == servo_bank_pkg::ADDR_UNIT_TEMPERATURE
        |=> rd_ack_o && rd_data_o == $past(unit_temperature_i))
        else $error("temperature read wrong");
    // Answers stand one cycle, then the data bus falls back to zero
    read_answer_a: assert property (rd_req_i |=> rd_ack_o)
        else $error("read not answered");
    read_idle_a: assert property (!rd_req_i
        |=> !rd_ack_o && !rd_unmapped_o && rd_data_o == 16'h0000)
        else $error("read answer outside its cycle");
    write_block_a: assert property (wr_req_i && !gain_load_i
        |=> wr_refused_o && $stable(kp_q))
        else $error("write altered a parameter");
    refuse_idle_a: assert property (!wr_req_i |=> !wr_refused_o)
        else $error("refusal without a write");

    gain_load_c: cover property (gain_load_i ##2 rd_req_i);
    shift_update_c: cover property (power_rise && shift_calc != 4'h0);
    write_refused_c: cover property (wr_req_i ##1 wr_refused_o);
    unmapped_read_c: cover property (rd_req_i ##1 rd_unmapped_o);
    write_mapped_c: cover property (wr_req_i
        && wr_addr_i == servo_bank_pkg::ADDR_Q_AXIS_PROPORTIONAL_GAIN);
endmodule // servo_status_parameter_bank

// file: hw/shift_count_calc.sv
// Finds how far a scaled velocity must shift right to fit sixteen bits
`timescale 1ns/1ps
module shift_count_calc (
    // Scaled velocity magnitude
    input wire logic [servo_bank_pkg::VEL_WIDTH-1:0] velocity_i,
    // Required right shift, saturated
    output logic [3:0] shift_o
);
    logic [3:0] need;

    // Highest set bit above the 16-bit field decides the shift
    always_comb
    begin
        need = 4'h0;
        for (int i = servo_bank_pkg::REF_WIDTH; i < servo_bank_pkg::VEL_WIDTH; i++)
        begin
            if (velocity_i[i])
            begin
                need = 4'(i - servo_bank_pkg::REF_WIDTH + 1);
            end
        end
        shift_o = (need > servo_bank_pkg::SHIFT_MAX) ? servo_bank_pkg::SHIFT_MAX : need;
    end
endmodule // shift_count_calc

// file: verif/fieldbus_master.sv
// Fieldbus master model: parameter reads, write attempts, reference scaling
`timescale 1ns/1ps
module fieldbus_master (
    // Clock
    input wire logic core_clk_i,
    // Answers from the bank
    input wire logic [15:0] rd_data_i,
    input wire logic rd_ack_i,
    input wire logic rd_unmapped_i,
    // Requests to the bank
    output logic rd_req_o,
    output logic [15:0] rd_addr_o,
    output logic wr_req_o,
    output logic [15:0] wr_addr_o
);
    initial
    begin
        rd_req_o = 1'b0;
        rd_addr_o = 16'h0000;
        wr_req_o = 1'b0;
        wr_addr_o = 16'h0000;
    end

    // Answer is registered on the taking edge and read at the next falling edge
    task automatic read_word(input logic [15:0] addr, output logic [15:0] data,
        output logic ack, output logic unm);
        @(negedge core_clk_i);
        rd_req_o = 1'b1;
        rd_addr_o = addr;
        @(negedge core_clk_i);
        rd_req_o = 1'b0;
        // Released address must not look like the last one
        rd_addr_o = ~addr;
        data = rd_data_i;
        ack = rd_ack_i;
        unm = rd_unmapped_i;
    endtask

    task automatic write_word(input logic [15:0] addr);
        @(negedge core_clk_i);
        wr_req_o = 1'b1;
        wr_addr_o = addr;
        @(negedge core_clk_i);
        wr_req_o = 1'b0;
        wr_addr_o = ~addr;
    endtask

    task automatic send_reference(input logic [27:0] vel, output logic [15:0] ref16);
        logic [15:0] sc;
        logic a;
        logic u;
        read_word(servo_bank_pkg::ADDR_REFERENCE_SHIFT_COUNT, sc, a, u);
        ref16 = 16'(vel >> sc[3:0]);
    endtask
endmodule // fieldbus_master

// file: verif/servo_status_parameter_bank_test.sv
// Self-checking bench of the servo parameter bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module servo_status_parameter_bank_test;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic rd_req, wr_req, rd_ack, rd_unm, wr_ref, a, u;
    logic [15:0] rd_addr, wr_addr, rd_data, kp_act, tnd_act, tnq_act, d, r;
    logic gain_load = 1'b0;
    logic [15:0] kp_c = 16'h0000, tnd_c = 16'h0000, tnq_c = 16'h0000;
    logic pwr_en = 1'b0;
    logic [27:0] vel = 28'h0000000;
    logic [3:0] shift;
    logic [14:0] st = 15'h0000;
    logic [15:0] p [5] = '{default: 16'h0000};
    int err_count = 0, n_compared = 0, cycles = 0;

    always #10 core_clk_i = ~core_clk_i;

    fieldbus_master i_master (.core_clk_i(core_clk_i), .rd_data_i(rd_data), .rd_ack_i(rd_ack),
        .rd_unmapped_i(rd_unm), .rd_req_o(rd_req), .rd_addr_o(rd_addr), .wr_req_o(wr_req),
        .wr_addr_o(wr_addr));

    servo_status_parameter_bank i_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .rd_req_i(rd_req), .rd_addr_i(rd_addr), .wr_req_i(wr_req), .wr_addr_i(wr_addr),
        .rd_data_o(rd_data), .rd_ack_o(rd_ack), .rd_unmapped_o(rd_unm), .wr_refused_o(wr_ref),
        .gain_load_i(gain_load), .kp_q_calc_i(kp_c), .tn_d_calc_i(tnd_c), .tn_q_calc_i(tnq_c),
        .kp_q_active_o(kp_act), .tn_d_active_o(tnd_act), .tn_q_active_o(tnq_act),
        .power_stage_en_i(pwr_en), .velocity_scaled_i(vel), .reference_shift_o(shift),
        .ready_i(st[0]), .switched_on_i(st[1]), .op_enabled_i(st[2]), .voltage_en_i(st[3]),
        .quick_stop_i(st[4]), .switch_on_dis_i(st[5]), .err_class0_i(st[6]),
        .halt_active_i(st[7]), .remote_i(st[8]), .target_reached_i(st[9]),
        .int_limit_i(st[10]), .mode_specific_i(st[11]), .op_error_i(st[12]),
        .op_end_i(st[13]), .ref_valid_i(st[14]), .profile_drive_state_i(p[0]),
        .profile_function_state_i(p[1]), .profile_movement_state_i(p[2]),
        .profile_input_state_i(p[3]), .unit_temperature_i(p[4]));

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Run should need about 200 cycles
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            test_done();
        end
    end

    task automatic chk_read(input logic [15:0] addr, input logic [15:0] exp);
        i_master.read_word(addr, d, a, u);
        `CHK({a, u, d}, {2'b10, exp})
    endtask

    task automatic t_reset();
        `CHK({kp_act, tnd_act, tnq_act}, {16'h0005, 16'h000d, 16'h000d})
        chk_read(servo_bank_pkg::ADDR_Q_AXIS_PROPORTIONAL_GAIN, 16'h0005);
        chk_read(servo_bank_pkg::ADDR_D_AXIS_INTEGRAL_TIME, 16'h000d);
        chk_read(servo_bank_pkg::ADDR_Q_AXIS_INTEGRAL_TIME, 16'h000d);
        chk_read(servo_bank_pkg::ADDR_REFERENCE_SHIFT_COUNT, 16'h0000);
    endtask

    // Loads below, at and above each range bound, except none at the gain minimum, d-axis time maximum or q-axis time minimum, then a plain value
    task automatic t_gain();
        logic [47:0] inp [4] = '{48'h0002ffff000c, 48'h319c000d7fff, 48'h319d000c8000,
            48'h123401000200};
        logic [47:0] exp [4] = '{48'h00057fff000d, 48'h319c000d7fff, 48'h319c000d7fff,
            48'h123401000200};
        foreach (inp[i])
        begin
            @(negedge core_clk_i);
            {kp_c, tnd_c, tnq_c} = inp[i];
            gain_load = 1'b1;
            @(negedge core_clk_i);
            gain_load = 1'b0;
            {kp_c, tnd_c, tnq_c} = ~inp[i];
            `CHK({kp_act, tnd_act, tnq_act}, exp[i])
            chk_read(servo_bank_pkg::ADDR_Q_AXIS_PROPORTIONAL_GAIN, exp[i][47:32]);
            chk_read(servo_bank_pkg::ADDR_D_AXIS_INTEGRAL_TIME, exp[i][31:16]);
            chk_read(servo_bank_pkg::ADDR_Q_AXIS_INTEGRAL_TIME, exp[i][15:0]);
        end
    endtask

    task automatic t_state();
        int pos [15] = '{0, 1, 2, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
        foreach (pos[i])
        begin
            st = 15'(1) << i;
            chk_read(servo_bank_pkg::ADDR_OPERATING_STATE_WORD, 16'(1) << pos[i]);
        end
        st = 15'h7fff;
        chk_read(servo_bank_pkg::ADDR_OPERATING_STATE_WORD, 16'hfff7);
    endtask

    // Velocity is changed while enable stays high: the count must hold
    task automatic t_shift();
        logic [27:0] v [5] = '{28'hfffffff, 28'h0100000, 28'h0010000, 28'h000ffff, 28'h0800000};
        logic [3:0] e [5] = '{4'hc, 4'h5, 4'h1, 4'h0, 4'h8};
        foreach (v[i])
        begin
            vel = v[i];
            pwr_en = 1'b1;
            repeat (4) @(negedge core_clk_i);
            `CHK(shift, e[i])
            vel = ~v[i];
            repeat (4) @(negedge core_clk_i);
            `CHK(shift, e[i])
            chk_read(servo_bank_pkg::ADDR_REFERENCE_SHIFT_COUNT, {12'h000, e[i]});
            i_master.send_reference(v[i], r);
            `CHK(r, 16'(v[i] >> e[i]))
            pwr_en = 1'b0;
            repeat (3) @(negedge core_clk_i);
        end
    endtask

    task automatic t_profile();
        logic [15:0] ad [5] = '{servo_bank_pkg::ADDR_PROFILE_DRIVE_STATE,
            servo_bank_pkg::ADDR_PROFILE_FUNCTION_STATE,
            servo_bank_pkg::ADDR_PROFILE_MOVEMENT_STATE,
            servo_bank_pkg::ADDR_PROFILE_INPUT_STATE, servo_bank_pkg::ADDR_UNIT_TEMPERATURE};
        foreach (ad[i])
        begin
            p[i] = 16'ha5c0 + 16'(i);
            chk_read(ad[i], 16'ha5c0 + 16'(i));
            p[i] = ~p[i];
            chk_read(ad[i], ~(16'ha5c0 + 16'(i)));
        end
    endtask

    task automatic t_write();
        i_master.write_word(servo_bank_pkg::ADDR_Q_AXIS_PROPORTIONAL_GAIN);
        `CHK(wr_ref, 1'b1)
        i_master.write_word(servo_bank_pkg::ADDR_REFERENCE_SHIFT_COUNT);
        `CHK(wr_ref, 1'b1)
        chk_read(servo_bank_pkg::ADDR_Q_AXIS_PROPORTIONAL_GAIN, 16'h1234);
        chk_read(servo_bank_pkg::ADDR_REFERENCE_SHIFT_COUNT, 16'h0008);
        i_master.read_word(16'h1105, d, a, u);
        `CHK({a, u, d}, {2'b11, 16'h0000})
        @(negedge core_clk_i);
        `CHK({rd_ack, rd_unm, wr_ref, rd_data}, 19'h00000)
    endtask

    initial
    begin
        repeat (16) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        t_reset();
        t_gain();
        t_state();
        t_shift();
        t_profile();
        t_write();
        test_done();
    end
endmodule // servo_status_parameter_bank_test
